// File: common/ufc_pkg.sv
/*
 * shared constants and carrier types of the dual-channel feature control
 * and reset bank: register indices, field positions, reset values, masks.
 * assumes one 50 MHz clock that also stands for the crystal clock.
 */
package ufc_pkg;

    localparam int CHANNELS = 2;
    localparam int REG_NUM = 32;
    localparam int IDX_W = 5;

    // register indices; byte address is the index within the channel
    localparam logic [4:0] IDX_THR = 5'h00;
    localparam logic [4:0] IDX_IER = 5'h01;
    localparam logic [4:0] IDX_ISR_FCR = 5'h02;
    localparam logic [4:0] IDX_LCR = 5'h03;
    localparam logic [4:0] IDX_MCR = 5'h04;
    localparam logic [4:0] IDX_LSR = 5'h05;
    localparam logic [4:0] IDX_MSR = 5'h06;
    localparam logic [4:0] IDX_SPR = 5'h07;
    localparam logic [4:0] IDX_EXTRA_FEATURE_CONTROL_REG = 5'h08;
    localparam logic [4:0] IDX_TXLVL = 5'h09;
    localparam logic [4:0] IDX_RXLVL = 5'h0a;
    localparam logic [4:0] IDX_EFR = 5'h0b;
    localparam logic [4:0] IDX_RESUME_CHAR_ONE = 5'h0c;
    localparam logic [4:0] IDX_PAUSE_CHAR_TWO = 5'h0f;
    localparam logic [4:0] IDX_CLOCK_PRESCALE_REG = 5'h14;
    localparam logic [4:0] IDX_ADVANCED_FEATURE_CONTROL_TWO = 5'h16;
    localparam logic [4:0] IDX_ADVANCED_FEATURE_CONTROL_ONE = 5'h17;
    localparam logic [4:0] IDX_DLL = 5'h18;
    localparam logic [4:0] IDX_DLM = 5'h19;
    localparam logic [4:0] IDX_LAST = 5'h19;

    // advanced_feature_control_one fields
    localparam int AF1_TSR_MODE = 0;
    localparam int AF1_SOFT_RESET_BIT = 1;
    localparam int AF1_FLOW_REMAP = 2;
    localparam int AF1_WAKE_EDGE = 4;
    localparam int AF1_CONCURRENT = 7;
    localparam logic [7:0] AF1_MASK = 8'h97;
    localparam logic [7:0] CLOCK_PRESCALE_REG_MASK = 8'h0f;

    // other fields that steer outputs
    localparam int IER_TXE = 1;
    localparam int IER_SLEEP = 4;
    localparam int LCR_BREAK = 6;
    localparam int MCR_DTR = 0;
    localparam int MCR_RTS = 1;
    localparam int MCR_OUT2 = 3;
    localparam int EFR_AUTO_RTS = 6;
    localparam int EFR_AUTO_CTS = 7;

    // reset and status values
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_SPR = 8'hff;
    localparam logic [7:0] ISR_NONE = 8'h01;
    localparam logic [7:0] ISR_TXE = 8'h02;
    localparam logic [7:0] LSR_RESET = 8'h60;
    localparam int LSR_THR_EMPTY = 5;
    localparam int LSR_TX_EMPTY = 6;
    localparam logic [7:0] READ_NONE = 8'h00;

    // soft reset length in crystal clocks
    localparam logic [2:0] RST_CYCLES = 3'h4;

    typedef struct packed {
        logic wr;
        logic rd;
        logic chan;
        logic [IDX_W-1:0] idx;
        logic [7:0] wdata;
    } ufc_bus_req_t;

    typedef struct packed {
        logic cd_b;
        logic ri_b;
        logic dsr_b;
        logic cts_b;
    } ufc_modem_in_t;

    typedef struct packed {
        logic fifo_below;
        logic fifo_empty;
        logic shift_empty;
        logic rx_hold;
    } ufc_core_stat_t;

endpackage

// File: hdl/ufc_feature_ctrl.sv
/*
 * feature control and reset bank of a dual uart channel pair, plus the
 * small word fifo that carries transmit bytes to the serial core.
 * assumes all inputs synchronous to clk; the serial core itself lives
 * outside and reports its fifo and shift status per channel.
 */
`timescale 1ns/1ps

module ufc_fifo import ufc_pkg::*; #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 4
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [$clog2(DEPTH):0] count
);
    localparam int PW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] rd_ptr;
        logic [PW-1:0] wr_ptr;
        logic [PW:0] cnt;
    } ufc_fifo_state_t;

    ufc_fifo_state_t s;
    ufc_fifo_state_t next_s;
    logic push;
    logic pop;

    // full exactly at depth; the count is one bit wider than the pointers
    assign in_ready = s.cnt < (PW+1)'(DEPTH);
    assign out_valid = s.cnt != '0;
    assign out_data = s.mem[s.rd_ptr];
    assign count = s.cnt;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // pointer wrap assumes a power-of-two depth
    always_comb begin
        next_s = s;
        if (push) begin
            next_s.mem[s.wr_ptr] = in_data;
            next_s.wr_ptr = s.wr_ptr + 1'b1;
        end
        if (pop) begin
            next_s.rd_ptr = s.rd_ptr + 1'b1;
        end
        next_s.cnt = s.cnt + (PW+1)'(push) - (PW+1)'(pop);
        if (flush) begin
            next_s.rd_ptr = '0;
            next_s.wr_ptr = '0;
            next_s.cnt = '0;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
endmodule

// Notes on behaviour
// - with concurrent write set, one host write lands in both channels at once
// - level wake mode: no sleep while receive input low; wake when it goes low
// - edge wake mode: sleep even with receive low; wake on any input change
// - remap bit moves hardware flow control onto terminal ready and data set ready
// - host sets soft reset bit; device resets then clears the bit itself
// - a reset completes within four crystal clocks; host waits that long
// - tsr mode 0: transmit-empty irq on fifo below trigger or fifo empty
// - tsr mode 1: below trigger, or fifo empty and last stop bit shifted out
// - pin reset and soft reset act alike, except only pin reset clears divisor latches and the 0x0c-0x0f characters
// - control, level, threshold and advanced registers clear; scratch all ones
// - interrupt status reads 0x01 after reset, no interrupt pending
// - line status reads 0x60 after reset, both transmitter-empty flags set
// - modem status change bits clear on reset; upper bits follow inputs
// - serial out, user output two, rts and dtr high; irq output floats
module ufc_feature_ctrl import ufc_pkg::*; #(
    parameter int FIFO_DEPTH = 4
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [5:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    output logic thr_ready,
    output logic tx_word_valid,
    input wire logic tx_word_ready,
    output logic [9:0] tx_word,
    input wire logic [1:0] serial_in,
    input wire ufc_modem_in_t [1:0] modem_in,
    input wire ufc_core_stat_t [1:0] core_stat,
    output logic [1:0] serial_out,
    output logic [1:0] user_output_two_b,
    output logic [1:0] request_to_send_b,
    output logic [1:0] terminal_ready_b,
    output logic [1:0] irq_out,
    output logic [1:0] irq_out_oe,
    output logic [1:0] tx_pause,
    output logic [1:0] asleep,
    output logic [1:0] reset_busy
);
    localparam int CW = $clog2(FIFO_DEPTH) + 1;

    typedef struct packed {
        logic [1:0][REG_NUM-1:0][7:0] regs;
        logic [1:0][3:0] delta;
        logic [1:0][3:0] modem_prev;
        logic [1:0][2:0] rst_cnt;
        logic [1:0] sleeping;
        logic [1:0] rx_prev;
        logic [7:0] rdata;
        logic [1:0] serial_out;
        logic [1:0] op2_b;
        logic [1:0] rts_b;
        logic [1:0] dtr_b;
        logic [1:0] irq;
        logic [1:0] irq_oe;
        logic [1:0] pause;
        logic [1:0] busy_q;
    } ufc_state_t;

    ufc_state_t s;
    ufc_state_t next_s;
    ufc_bus_req_t req;
    logic fifo_push;
    logic fifo_flush;
    logic [CW-1:0] fifo_count;
    logic bcast;

    assign req = '{wr: wr, rd: rd, chan: addr[5], idx: addr[4:0], wdata: wdata};

    // a write to either channel is broadcast when either copy holds the bit
    assign bcast = s.regs[0][IDX_ADVANCED_FEATURE_CONTROL_ONE][AF1_CONCURRENT] | s.regs[1][IDX_ADVANCED_FEATURE_CONTROL_ONE][AF1_CONCURRENT];

    // transmit bytes go into the fifo tagged with their channel mask
    assign fifo_push = req.wr && req.idx == IDX_THR && (s.rst_cnt[req.chan] == '0);
    assign fifo_flush = (s.rst_cnt[0] != '0) || (s.rst_cnt[1] != '0);

    ufc_fifo #(
        .WIDTH(10),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst_b(rst_b),
        .flush(fifo_flush),
        .in_valid(fifo_push),
        .in_ready(thr_ready),
        .in_data({bcast | req.chan, bcast | ~req.chan, req.wdata}),
        .out_valid(tx_word_valid),
        .out_ready(tx_word_ready),
        .out_data(tx_word),
        .count(fifo_count)
    );

    // register value that a soft reset leaves behind; divisor latches and the 0x0c-0x0f characters keep theirs
    function automatic logic [7:0] reset_value(input logic [4:0] idx, input logic [7:0] cur);
        if (idx == IDX_SPR) begin
            return RST_SPR;
        end else if (idx == IDX_DLL || idx == IDX_DLM || (idx >= IDX_RESUME_CHAR_ONE && idx <= IDX_PAUSE_CHAR_TWO)) begin
            return cur;
        end else begin
            return RST_ZERO;
        end
    endfunction

    // reserved bits never take a write
    function automatic logic [7:0] write_mask(input logic [4:0] idx);
        if (idx == IDX_ADVANCED_FEATURE_CONTROL_ONE) begin
            return AF1_MASK;
        end else if (idx == IDX_CLOCK_PRESCALE_REG) begin
            return CLOCK_PRESCALE_REG_MASK;
        end else begin
            return 8'hff;
        end
    endfunction

    // transmit-empty interrupt condition of one channel
    function automatic logic txe_irq(input logic [7:0] interrupt_enable_reg, input logic [7:0] af1, input ufc_core_stat_t st);
        logic empty_hit;
        empty_hit = af1[AF1_TSR_MODE] ? (st.fifo_empty && st.shift_empty) : st.fifo_empty;
        return interrupt_enable_reg[IER_TXE] && (st.fifo_below || empty_hit);
    endfunction

    always_comb begin
        logic c;
        logic [7:0] interrupt_enable_reg;
        logic [7:0] af1;
        logic [7:0] modem_control_reg;
        logic [7:0] enhanced_feature_reg;
        logic [3:0] mnow;
        logic busy;
        logic remap;
        logic wake;
        logic rd_msr;
        c = 1'b0;
        interrupt_enable_reg = '0;
        af1 = '0;
        modem_control_reg = '0;
        enhanced_feature_reg = '0;
        mnow = '0;
        busy = 1'b0;
        remap = 1'b0;
        wake = 1'b0;
        rd_msr = 1'b0;
        next_s = s;
        next_s.rdata = READ_NONE;
        for (int ch = 0; ch < CHANNELS; ch++) begin
            c = ch[0];
            busy = s.rst_cnt[ch] != '0;
            interrupt_enable_reg = s.regs[ch][IDX_IER];
            af1 = s.regs[ch][IDX_ADVANCED_FEATURE_CONTROL_ONE];
            modem_control_reg = s.regs[ch][IDX_MCR];
            enhanced_feature_reg = s.regs[ch][IDX_EFR];
            mnow = ~modem_in[ch];
            remap = af1[AF1_FLOW_REMAP];
            rd_msr = req.rd && req.chan == c && req.idx == IDX_MSR;

            // change bits: a change in the read cycle survives the clear
            next_s.modem_prev[ch] = mnow;
            if (rd_msr) begin
                next_s.delta[ch] = '0;
            end
            next_s.delta[ch] = next_s.delta[ch] | (mnow ^ s.modem_prev[ch]);

            // host write, refused while a reset sequence runs
            if (req.wr && !busy && (req.chan == c || bcast) && req.idx <= IDX_LAST) begin
                if (req.idx != IDX_LSR && req.idx != IDX_MSR && req.idx != IDX_TXLVL && req.idx != IDX_RXLVL
                    && req.idx != IDX_THR) begin
                    next_s.regs[ch][req.idx] = req.wdata & write_mask(req.idx);
                end
                if (req.idx == IDX_ADVANCED_FEATURE_CONTROL_ONE && req.wdata[AF1_SOFT_RESET_BIT]) begin
                    next_s.rst_cnt[ch] = RST_CYCLES;
                end
            end

            // soft reset: hold reset values, bit reads one until the last cycle
            if (busy) begin
                next_s.rst_cnt[ch] = s.rst_cnt[ch] - 1'b1;
                for (int i = 0; i < REG_NUM; i++) begin
                    next_s.regs[ch][i] = reset_value(5'(i), s.regs[ch][i]);
                end
                next_s.regs[ch][IDX_ADVANCED_FEATURE_CONTROL_ONE][AF1_SOFT_RESET_BIT] = s.rst_cnt[ch] != 3'h1;
                next_s.delta[ch] = '0;
                next_s.sleeping[ch] = 1'b0;
            end

            // sleep entry and wake-up on the serial input
            wake = af1[AF1_WAKE_EDGE] ? (serial_in[ch] != s.rx_prev[ch]) : !serial_in[ch];
            next_s.rx_prev[ch] = serial_in[ch];
            if (!busy) begin
                if (!interrupt_enable_reg[IER_SLEEP]) begin
                    next_s.sleeping[ch] = 1'b0;
                end else if (s.sleeping[ch]) begin
                    next_s.sleeping[ch] = !wake;
                end else begin
                    next_s.sleeping[ch] = af1[AF1_WAKE_EDGE] || serial_in[ch];
                end
            end

            // pins follow the register copy; after reset serial out, output two, rts and dtr idle high
            next_s.serial_out[ch] = !s.regs[ch][IDX_LCR][LCR_BREAK];
            next_s.op2_b[ch] = !modem_control_reg[MCR_OUT2];
            next_s.rts_b[ch] = !modem_control_reg[MCR_RTS]
                || (enhanced_feature_reg[EFR_AUTO_RTS] && !remap && core_stat[ch].rx_hold);
            next_s.dtr_b[ch] = !modem_control_reg[MCR_DTR]
                || (enhanced_feature_reg[EFR_AUTO_RTS] && remap && core_stat[ch].rx_hold);
            next_s.pause[ch] = enhanced_feature_reg[EFR_AUTO_CTS]
                && (remap ? modem_in[ch].dsr_b : modem_in[ch].cts_b);
            next_s.irq[ch] = !busy && txe_irq(interrupt_enable_reg, af1, core_stat[ch]);
            next_s.irq_oe[ch] = !busy && modem_control_reg[MCR_OUT2];

            // read data stands in the cycle after the strobe
            if (req.rd && req.chan == c) begin
                unique case (req.idx)
                    IDX_THR: next_s.rdata = READ_NONE;
                    IDX_ISR_FCR: next_s.rdata = (!busy && txe_irq(interrupt_enable_reg, af1, core_stat[ch])) ? ISR_TXE : ISR_NONE;
                    IDX_LSR: begin
                        next_s.rdata = busy ? LSR_RESET : READ_NONE;
                        next_s.rdata[LSR_THR_EMPTY] = busy || core_stat[ch].fifo_empty;
                        next_s.rdata[LSR_TX_EMPTY] = busy || (core_stat[ch].fifo_empty && core_stat[ch].shift_empty);
                    end
                    IDX_MSR: next_s.rdata = {mnow, s.delta[ch]};
                    IDX_TXLVL: next_s.rdata = busy ? RST_ZERO : 8'(fifo_count);
                    IDX_RXLVL: next_s.rdata = RST_ZERO;
                    IDX_ADVANCED_FEATURE_CONTROL_ONE: next_s.rdata = s.regs[ch][IDX_ADVANCED_FEATURE_CONTROL_ONE] & AF1_MASK;
                    default: next_s.rdata = (req.idx <= IDX_LAST) ? s.regs[ch][req.idx] : READ_NONE;
                endcase
            end

            // busy flag registered beside the counter so the pin comes from a flop
            next_s.busy_q[ch] = next_s.rst_cnt[ch] != '0;
        end
    end

    // pin reset gives the soft reset picture, but also clears divisor latches and the 0x0c-0x0f characters
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s <= '0;
            s.regs[0][IDX_SPR] <= RST_SPR;
            s.regs[1][IDX_SPR] <= RST_SPR;
            s.serial_out <= 2'h3;
            s.op2_b <= 2'h3;
            s.rts_b <= 2'h3;
            s.dtr_b <= 2'h3;
        end else begin
            s <= next_s;
        end
    end

    assign rdata = s.rdata;
    assign serial_out = s.serial_out;
    assign user_output_two_b = s.op2_b;
    assign request_to_send_b = s.rts_b;
    assign terminal_ready_b = s.dtr_b;
    assign irq_out = s.irq;
    assign irq_out_oe = s.irq_oe;
    assign tx_pause = s.pause;
    assign asleep = s.sleeping;
    assign reset_busy = s.busy_q;
endmodule

// File: tb/tb.sv
/* self-checking bench of the feature control bank with a serial core model.
   assumes 50 MHz clk, rdata one cycle after rd, idle core status 4'h6. */
`timescale 1ns/1ps
module tb import ufc_pkg::*;;
    logic clk, tx_word_valid, tx_word_ready, thr_ready, got;
    logic rst_b = 1'b0, wr = 1'b0, rd = 1'b0, stall = 1'b0, rd_q = 1'b0;
    logic [5:0] addr = 6'h00;
    logic [7:0] wdata = 8'h00, rdata, v, w;
    logic [9:0] tx_word, got_word;
    logic [1:0] serial_in = 2'b11, serial_out, user_output_two_b, request_to_send_b, terminal_ready_b;
    logic [1:0] irq_out, irq_out_oe, tx_pause, asleep, reset_busy;
    ufc_modem_in_t [1:0] modem_in = 8'hff;
    ufc_core_stat_t [1:0] core_stat = 8'h66;
    logic [7:0] exp_rd[$];
    logic [9:0] exp_word[$];
    logic [4:0] rw_idx[14] = '{IDX_IER, IDX_LCR, IDX_MCR, IDX_SPR, IDX_EXTRA_FEATURE_CONTROL_REG, IDX_EFR, 5'h10, 5'h11, 5'h12,
        5'h13, IDX_CLOCK_PRESCALE_REG, 5'h15, IDX_ADVANCED_FEATURE_CONTROL_TWO, IDX_ADVANCED_FEATURE_CONTROL_ONE};
    logic [4:0] irq_case[5] = '{5'h12, 5'h0a, 5'h1b, 5'h1c, 5'h00}; // {irq, mode, below, empty, shift}
    int error_cnt = 0, samples_checked = 0, cycles = 0;
    integer seed = 32'ha986_a88e;

    ufc_feature_ctrl #(.FIFO_DEPTH(4)) DUT (.clk, .rst_b, .addr, .wdata, .wr, .rd, .rdata, .thr_ready,
        .tx_word_valid, .tx_word_ready, .tx_word, .serial_in, .modem_in, .core_stat, .serial_out,
        .user_output_two_b, .request_to_send_b, .terminal_ready_b, .irq_out, .irq_out_oe, .tx_pause,
        .asleep, .reset_busy);
    ufc_core_model u_core (.clk, .rst_b, .stall, .tx_word_valid, .tx_word, .tx_word_ready, .got, .got_word);

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic chk(input string what, input logic [9:0] seen, input logic [9:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wrap_up();
        $display("comparisons %0d, mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // results are compared here in issue order; drivers only note expectations
    always @(posedge clk) begin
        cycles <= cycles + 1;
        rd_q <= rd && rst_b;
        if (rd_q) chk("rdata", rdata, exp_rd.pop_front());
        if (got) chk("tx word", got_word, exp_word.pop_front());
        if (cycles == 8000) begin
            error_cnt++;
            wrap_up();
        end
    end

    task automatic wr_reg(input logic ch, input logic [4:0] idx, input logic [7:0] d);
        @(posedge clk);
        addr <= {ch, idx};
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic ch, input logic [4:0] idx, input logic [7:0] e);
        exp_rd.push_back(e);
        @(posedge clk);
        addr <= {ch, idx};
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
    endtask

    task automatic wait_n(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic done(input string s);
        $display("test %s finished, %0d mismatches so far", s, error_cnt);
    endtask

    // read/write registers, isr, lsr, msr, txlvl and five pins of one channel at their reset state
    task automatic check_reset(input logic ch);
        foreach (rw_idx[i]) rd_reg(ch, rw_idx[i], rw_idx[i] == IDX_SPR ? RST_SPR : RST_ZERO);
        rd_reg(ch, IDX_ISR_FCR, ISR_NONE);
        rd_reg(ch, IDX_LSR, LSR_RESET);
        rd_reg(ch, IDX_MSR, RST_ZERO);
        rd_reg(ch, IDX_TXLVL, RST_ZERO);
        wait_n(1);
        chk("idle pins", {serial_out[ch], user_output_two_b[ch], request_to_send_b[ch],
            terminal_ready_b[ch], irq_out_oe[ch]}, 10'h01e);
    endtask

    // pin reset also puts the far-side inputs back to idle
    task automatic pin_reset();
        @(posedge clk);
        rst_b <= 1'b0;
        modem_in <= 8'hff;
        core_stat <= 8'h66;
        serial_in <= 2'b11;
        wait_n(1);
        chk("pins in reset", {serial_out, user_output_two_b, request_to_send_b, terminal_ready_b,
            irq_out_oe}, 10'h3fc);
        @(posedge clk);
        rst_b <= 1'b1;
    endtask

    initial begin
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        check_reset(1'b0);
        check_reset(1'b1);
        done("reset values");
        foreach (rw_idx[i]) begin
            v = $random(seed);
            if (rw_idx[i] == IDX_ADVANCED_FEATURE_CONTROL_ONE) v = v & 8'h7d;
            wr_reg(1'b0, rw_idx[i], v);
            rd_reg(1'b0, rw_idx[i], rw_idx[i] == IDX_ADVANCED_FEATURE_CONTROL_ONE ? v & AF1_MASK :
                rw_idx[i] == IDX_CLOCK_PRESCALE_REG ? v & CLOCK_PRESCALE_REG_MASK : v);
        end
        w = $random(seed);
        wr_reg(1'b1, IDX_SPR, w);
        wr_reg(1'b0, IDX_ADVANCED_FEATURE_CONTROL_ONE, 8'h02);
        #1;
        chk("reset busy", reset_busy, 10'h001);
        wait_n(6);
        check_reset(1'b0);
        rd_reg(1'b1, IDX_SPR, w);
        done("soft reset");
        pin_reset();
        check_reset(1'b1);
        done("pin reset");
        // concurrent write reaches both channels, then only the addressed one
        wr_reg(1'b0, IDX_ADVANCED_FEATURE_CONTROL_ONE, 8'h80);
        wr_reg(1'b0, IDX_SPR, 8'h5a);
        exp_word.push_back({2'b11, 8'h41});
        wr_reg(1'b0, IDX_THR, 8'h41);
        rd_reg(1'b1, IDX_SPR, 8'h5a);
        wr_reg(1'b0, IDX_ADVANCED_FEATURE_CONTROL_ONE, 8'h00);
        wr_reg(1'b0, IDX_SPR, 8'ha5);
        rd_reg(1'b1, IDX_SPR, 8'h5a);
        exp_word.push_back({2'b10, 8'h42});
        wr_reg(1'b1, IDX_THR, 8'h42);
        done("concurrent write");
        // fill the fifo while the core stalls; the fifth byte is dropped
        wait_n(6);
        stall <= 1'b1;
        wait_n(2);
        for (int i = 0; i < 5; i++) begin
            v = $random(seed);
            if (i < 4) exp_word.push_back({2'b01, v});
            else begin
                #1;
                chk("fifo full", thr_ready, 10'h000);
            end
            wr_reg(1'b0, IDX_THR, v);
        end
        rd_reg(1'b0, IDX_TXLVL, 8'h04);
        @(posedge clk);
        stall <= 1'b0;
        wait_n(20);
        chk("words left", 10'(exp_word.size()), 10'h000);
        done("fifo");
        // flow control on rts/cts, then moved to dtr/dsr
        wr_reg(1'b0, IDX_EFR, 8'hc0);
        wr_reg(1'b0, IDX_MCR, 8'h03);
        @(posedge clk);
        modem_in[0] <= 4'hd;
        core_stat[0] <= 4'h7;
        for (int m = 0; m < 2; m++) begin
            wr_reg(1'b0, IDX_ADVANCED_FEATURE_CONTROL_ONE, {5'h00, m[0], 2'b00});
            wait_n(3);
            chk("flow pins", {tx_pause[0], request_to_send_b[0], terminal_ready_b[0]}, m ? 10'h001 : 10'h006);
        end
        pin_reset();
        done("flow remap");
        wr_reg(1'b0, IDX_IER, 8'h02);
        foreach (irq_case[i]) begin
            wr_reg(1'b0, IDX_ADVANCED_FEATURE_CONTROL_ONE, {7'h00, irq_case[i][3]});
            @(posedge clk);
            core_stat[0] <= {irq_case[i][2:0], 1'b0};
            wait_n(3);
            chk("tx empty irq", irq_out[0], irq_case[i][4]);
            rd_reg(1'b0, IDX_ISR_FCR, irq_case[i][4] ? ISR_TXE : ISR_NONE);
        end
        pin_reset();
        done("tx empty irq");
        wr_reg(1'b0, IDX_IER, 8'h10);
        @(posedge clk);
        serial_in[0] <= 1'b0;
        wait_n(4);
        chk("asleep low rx", asleep[0], 10'h000);
        serial_in[0] <= 1'b1;
        wait_n(4);
        chk("asleep", asleep[0], 10'h001);
        serial_in[0] <= 1'b0;
        wait_n(3);
        chk("woken", asleep[0], 10'h000);
        wr_reg(1'b0, IDX_ADVANCED_FEATURE_CONTROL_ONE, 8'h10);
        wait_n(4);
        chk("edge mode sleep", asleep[0], 10'h001);
        serial_in[0] <= 1'b1;
        wait_n(1);
        chk("edge wake", asleep[0], 10'h000);
        pin_reset();
        done("sleep");
        wrap_up();
    end
endmodule

// File: tb/ufc_core_model.sv
/* stand-in for the serial core: drains transmit words from the bank's fifo.
   assumes the valid/ready drain handshake; stall holds ready low. */
`timescale 1ns/1ps
module ufc_core_model (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic stall,
    input wire logic tx_word_valid,
    input wire logic [9:0] tx_word,
    output logic tx_word_ready,
    output logic got,
    output logic [9:0] got_word
);
    // ready only every other cycle, so the fifo sees back pressure unstalled too
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_word_ready <= 1'b0;
            got <= 1'b0;
            got_word <= 10'h000;
        end else begin
            tx_word_ready <= !stall && !tx_word_ready;
            got <= tx_word_valid && tx_word_ready;
            got_word <= tx_word;
        end
    end
endmodule

// File: tb/ufc_feature_ctrl_properties.sv
/* concurrent checks on the top ports of the feature control bank.
   assumes one clock and the async active-low reset; channel a is watched. */
`timescale 1ns/1ps
module ufc_ctrl_props import ufc_pkg::*; (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [5:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    input wire ufc_modem_in_t [1:0] modem_in,
    input wire logic [1:0] serial_in,
    input wire logic tx_word_valid,
    input wire logic [9:0] tx_word,
    input wire logic [1:0] serial_out,
    input wire logic [1:0] user_output_two_b,
    input wire logic [1:0] request_to_send_b,
    input wire logic [1:0] terminal_ready_b,
    input wire logic [1:0] irq_out_oe,
    input wire logic [1:0] asleep,
    input wire logic [1:0] reset_busy
);
    // single domain, so one clock and one disable for all
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    a_soft_reset_len: assert property (
        wr && addr == 6'h17 && wdata[1] && !reset_busy[0] |=> reset_busy[0] [*4] ##1 !reset_busy[0])
        else $error("soft reset window not four cycles");
    a_soft_bit_clear: assert property (
        rd && addr == 6'h17 && !reset_busy[0] |=> !rdata[1]) else $error("soft reset bit stuck");
    a_afcr_reserved: assert property (
        rd && addr[4:0] == IDX_ADVANCED_FEATURE_CONTROL_ONE |=> (rdata & ~AF1_MASK) == 8'h00) else $error("reserved bits read set");
    a_reset_pins: assert property (
        $fell(reset_busy[0]) |=> serial_out[0] && user_output_two_b[0] && request_to_send_b[0]
        && terminal_ready_b[0] && !irq_out_oe[0]) else $error("pins not idle after soft reset");
    a_wake_on_low: assert property (
        $fell(serial_in[0]) |-> ##[1:2] !asleep[0]) else $error("no wake on receive low");
    a_word_enables: assert property (
        tx_word_valid |-> tx_word[9:8] != 2'b00) else $error("word without channel");
    a_msr_pins: assert property (
        rd && addr == 6'h06 && $stable(modem_in) |=> rdata[7:4] == ~$past(modem_in[0]))
        else $error("modem status upper bits wrong");
    a_irq_float: assert property (
        irq_out_oe[0] |-> !user_output_two_b[0]) else $error("irq driven without output two");
endmodule

bind ufc_feature_ctrl ufc_ctrl_props u_props (.clk, .rst_b, .addr, .wdata, .wr, .rd, .rdata, .modem_in,
    .serial_in, .tx_word_valid, .tx_word, .serial_out, .user_output_two_b, .request_to_send_b,
    .terminal_ready_b, .irq_out_oe, .asleep, .reset_busy);
